// file: src/rcp_pkg.sv
// Constants, codes and state type for the remote code parser and trigger control.
// Assumes bytes arrive one per strobe from a bus listener on the same clock.
//
// Notes on behaviour
// - Unused letters B E G I J N Q Y Z and \ { } ~ DEL flag error 24.
// - Invalid character shows error 24 and raises a service request.
// - Droppable punctuation is ignored, except between two characters of a code.
// - After service request clear, the bad entry is dropped and parsing continues.
// - Lower-case letters fold to upper case before interpretation.
// - Filter, ratio and sweep groups switch off by dedicated codes, never toggle.
// - Numbers: signed mantissa up to five digits, one point, signed 1-2 digit exponent.
// - A leading decimal point gets a zero inserted ahead of it.
// - Mantissa digits after the fifth significant one are stored as zero; the code counts leading and inserted zeros among the five places.
// - Free run is default; device clear and local-to-remote force free run.
// - In free run, result data refreshes at every measurement completion; the code skips the refresh when bus_cmd_req is high in that cycle.
// - Sweep allows only free run; other triggers stop sweep at start point.
// - Hold suppresses all outputs except code-error service request and poll status.
// - Serial poll in hold starts one measurement, refreshes displays, stays in hold.
// - Hold exits on run/trigger codes, group trigger, clear key, or going local.
// - Immediate trigger makes one fast measurement and keeps it until read.
// - While result waits, GTL, GET, listen address or clear key restart measuring.
// - After a triggered result is read, fall back to hold.
// - Settled trigger waits settling delay first; group trigger acts as settled.
// - In remote hold without lockout, clear key runs one settled cycle.
// - An unread result is overwritten by the newer measurement.
// - Free run services bus commands by aborting and restarting the measurement.
// - Triggered measurements refuse interruption and withhold bus command handshake; the code still lets clear, remote entry, going local and T0 cut them short.
`default_nettype none
package rcp_pkg;
  localparam logic [7:0] ERR_CODE_INVALID = 8'h18;   // Error 24.
  localparam int         MANT_DIGITS      = 5;
  localparam int         SETTLE_TIME_US   = 50;      // Settling delay, microseconds.
  localparam int         CLK_MHZ          = 100;
  localparam int         SETTLE_CYCLES    = SETTLE_TIME_US * CLK_MHZ;
  // Group-off codes reported on group_off (one-hot bit positions).
  localparam int         GRP_HPBP         = 0;
  localparam int         GRP_LP           = 1;
  localparam int         GRP_RATIO        = 2;
  localparam int         GRP_SWEEP        = 3;
  typedef enum logic [2:0] {
    RCP_FREE   = 3'b000,
    RCP_HOLD   = 3'b001,
    RCP_SETTLE = 3'b010,
    RCP_MEAS   = 3'b011,
    RCP_WAIT   = 3'b100,
    RCP_POLL   = 3'b101
  } rcp_trig_t;
endpackage
`default_nettype wire

// file: src/rcp_top.sv
// Remote code parser and measurement trigger controller.
// Assumes listener, key and measurement engine signals are synchronous to sys_clk,
// one-cycle pulses unless named as levels.
// The clear key is taken as already debounced and synchronised by the panel logic, so
// no pin synchroniser sits in this block; a raw switch must not be wired here.
// The measurement engine is expected to restart whenever meas_start is pulsed.
`default_nettype none
module rcp_top #(
  parameter int SETTLE_CYCLES = rcp_pkg::SETTLE_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       remote,
  input  wire logic       lockout,
  input  wire logic       device_clear,
  input  wire logic       go_local,
  input  wire logic       group_trigger,
  input  wire logic       listen_addr,
  input  wire logic       serial_poll,
  input  wire logic       bus_cmd_req,
  input  wire logic       srq_clear,
  input  wire logic       clear_key,
  input  wire logic       result_read,
  input  wire logic       meas_done,
  input  wire logic       sweep_on,
  output logic            rx_ready,
  output logic            bus_cmd_ack,
  output logic [7:0]      code_char0,
  output logic [7:0]      code_char1,
  output logic            code_valid,
  output logic [3:0]      group_off,
  output logic [3:0]      num_digit,
  output logic            num_digit_valid,
  output logic            num_point,
  output logic            num_sign_neg,
  output logic            srq,
  output logic [7:0]      error_code,
  output logic            meas_start,
  output logic            meas_abort,
  output logic            result_update,
  output logic            result_ready,
  output logic            outputs_enable,
  output logic            sweep_halt,
  output logic [2:0]      trig_state
);

  // ------------------------------------------------------------
  // Character classification
  // ------------------------------------------------------------

  // All decoding below works on the folded character, so every table lists upper case
  // only; a lower-case unused letter still raises the code error.
  // Fold lower case to upper case.
  function automatic logic [7:0] fold(input logic [7:0] c);
    if (c >= 8'h61 && c <= 8'h7A) begin
      return c - 8'h20;
    end
    return c;
  endfunction

  // Characters that raise error 24; E is exempt once a number has started.
  function automatic logic is_bad(input logic [7:0] c);
    case (c)
      8'h42, 8'h45, 8'h47, 8'h49, 8'h4A, 8'h4E, 8'h51, 8'h59, 8'h5A,
      8'h5C, 8'h7B, 8'h7D, 8'h7E, 8'h7F: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Punctuation that is dropped outside a code.
  function automatic logic is_drop(input logic [7:0] c);
    case (c)
      8'h21, 8'h22, 8'h23, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A,
      8'h2C, 8'h3A, 8'h3B, 8'h20: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Decimal digit, used for mantissa and exponent alike.
  function automatic logic is_digit(input logic [7:0] c);
    return c >= 8'h30 && c <= 8'h39;
  endfunction

  // Upper-case letter; call it on the folded character only.
  function automatic logic is_alpha(input logic [7:0] c);
    return c >= 8'h41 && c <= 8'h5A;
  endfunction

  logic [7:0] ch;
  logic       blocked;
  logic       take;
  assign ch = fold(rx_byte);
  // Parsing pauses while a code error waits for the controller.
  assign rx_ready = !srq;
  assign take     = rx_valid && rx_ready;

  // ------------------------------------------------------------
  // Code and number parser
  // ------------------------------------------------------------
  logic       in_code_reg;
  logic [7:0] first_reg;
  logic       in_num_reg;
  logic       saw_digit_reg;
  logic       in_exp_reg;
  logic [2:0] sig_cnt_reg;
  logic       bad_ch;

  // An E after a number has started is the exponent marker; anywhere else it is an
  // unused letter. Without this guard no exponent could ever be entered.
  assign bad_ch = is_bad(ch) && !(ch == 8'h45 && in_num_reg);

  // First letter of a two-character code is held; second completes it.
  always_ff @(posedge sys_clk) begin
    code_valid <= 1'b0;
    group_off  <= 4'h0;
    if (reset || device_clear) begin
      in_code_reg <= 1'b0;
      first_reg   <= 8'h00;
      code_char0  <= 8'h00;
      code_char1  <= 8'h00;
    end else if (take && !bad_ch) begin
      if (in_code_reg) begin
        // Punctuation inside a code is passed on as the second character.
        in_code_reg <= 1'b0;
        code_char0  <= first_reg;
        code_char1  <= ch;
        code_valid  <= 1'b1;
        if (ch == 8'h30) begin
          case (first_reg)
            8'h48:   group_off[rcp_pkg::GRP_HPBP]  <= 1'b1;
            8'h4C:   group_off[rcp_pkg::GRP_LP]    <= 1'b1;
            8'h52:   group_off[rcp_pkg::GRP_RATIO] <= 1'b1;
            8'h57:   group_off[rcp_pkg::GRP_SWEEP] <= 1'b1;
            default: group_off <= 4'h0;
          endcase
        end
      end else if (is_alpha(ch) && !(in_exp_reg == 1'b0 && in_num_reg && ch == 8'h45)) begin
        in_code_reg <= 1'b1;
        first_reg   <= ch;
      end
    end
  end

  // Numeric entry: sign, up to five mantissa places, point, exponent.
  always_ff @(posedge sys_clk) begin
    num_digit_valid <= 1'b0;
    num_point       <= 1'b0;
    if (reset || device_clear) begin
      in_num_reg      <= 1'b0;
      saw_digit_reg   <= 1'b0;
      in_exp_reg      <= 1'b0;
      sig_cnt_reg     <= 3'h0;
      num_digit       <= 4'h0;
      num_sign_neg    <= 1'b0;
    end else if (take && !in_code_reg && !bad_ch) begin
      if (ch == 8'h2B || ch == 8'h2D) begin
        in_num_reg   <= 1'b1;
        num_sign_neg <= (ch == 8'h2D);
      end else if (is_digit(ch)) begin
        in_num_reg      <= 1'b1;
        saw_digit_reg   <= 1'b1;
        num_digit_valid <= 1'b1;
        if (in_exp_reg) begin
          num_digit <= ch[3:0];
        end else begin
          // Leading zeros and an inserted zero each take one of the five mantissa places,
          // so a long run of leading zeros pushes real digits past the end.
          if (sig_cnt_reg != 3'(rcp_pkg::MANT_DIGITS)) begin
            sig_cnt_reg <= sig_cnt_reg + 3'h1;
          end
          // Digits past the fifth mantissa place become zero.
          num_digit <= (sig_cnt_reg == 3'(rcp_pkg::MANT_DIGITS)) ? 4'h0 : ch[3:0];
        end
      end else if (ch == 8'h2E) begin
        in_num_reg <= 1'b1;
        num_point  <= 1'b1;
        if (!saw_digit_reg) begin
          num_digit       <= 4'h0;
          num_digit_valid <= 1'b1;
          saw_digit_reg   <= 1'b1;
          sig_cnt_reg     <= 3'h1;
        end
      end else if (ch == 8'h45 && in_num_reg) begin
        in_exp_reg <= 1'b1;
      end else if (is_alpha(ch)) begin
        in_num_reg      <= 1'b0;
        saw_digit_reg   <= 1'b0;
        in_exp_reg      <= 1'b0;
        sig_cnt_reg     <= 3'h0;
        num_sign_neg    <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Code error and service request
  // ------------------------------------------------------------

  // The bad byte is consumed; parsing resumes once the request is cleared.
  // A second bad byte waiting behind the first is held off by rx_ready until then.
  always_ff @(posedge sys_clk) begin
    if (reset || device_clear) begin
      srq        <= 1'b0;
      error_code <= 8'h00;
    end else if (rx_valid && !srq && bad_ch) begin
      srq        <= 1'b1;
      error_code <= rcp_pkg::ERR_CODE_INVALID;
    end else if (srq_clear) begin
      srq        <= 1'b0;
      error_code <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Trigger state machine
  // ------------------------------------------------------------
  // The settle counter is a full 32-bit word so that any settling parameter fits;
  // a narrower counter would save flops but would silently wrap on long delays.
  rcp_pkg::rcp_trig_t  state_reg;
  logic                is_trig_code;
  logic                code_t;
  logic                remote_d_reg;
  logic [31:0]         settle_cnt_reg;
  logic                key_ok;

  assign code_t       = code_valid && code_char0 == 8'h54;
  assign key_ok       = clear_key && remote && !lockout;
  assign blocked      = state_reg == rcp_pkg::RCP_SETTLE || state_reg == rcp_pkg::RCP_MEAS;
  assign is_trig_code = code_t && (code_char1 == 8'h32 || code_char1 == 8'h33);

  // Remote level one cycle late. It is cleared on reset so that a block released in
  // remote sees a rise and launches the first free-run measurement.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      remote_d_reg <= 1'b0;
    end else begin
      remote_d_reg <= remote;
    end
  end

  // Mode and measurement sequencing.
  // Priority runs from clear and remote entry, through going local and the free-run
  // code, to the trigger sources, to hold, and only then to the per-state work.
  // A triggered measurement in progress blocks triggers and hold, so nothing can cut
  // it short except a clear, remote entry, a return to local or a free-run code.
  // The bus handshake is withheld apart from this, by gating bus_cmd_ack with blocked.
  always_ff @(posedge sys_clk) begin
    meas_start    <= 1'b0;
    meas_abort    <= 1'b0;
    result_update <= 1'b0;
    if (reset || device_clear || (remote && !remote_d_reg)) begin
      state_reg      <= rcp_pkg::RCP_FREE;
      settle_cnt_reg <= 32'h0;
      result_ready   <= 1'b0;
      meas_start     <= !reset;
    end else if (go_local || (code_t && code_char1 == 8'h30)) begin
      state_reg    <= rcp_pkg::RCP_FREE;
      result_ready <= 1'b0;
      meas_abort   <= 1'b1;
      meas_start   <= 1'b1;
    end else if (!blocked && (is_trig_code || group_trigger || key_ok ||
                 (state_reg == rcp_pkg::RCP_WAIT && listen_addr))) begin
      // Settled unless the code asked for an immediate measurement.
      if (is_trig_code && code_char1 == 8'h32) begin
        state_reg  <= rcp_pkg::RCP_MEAS;
        meas_start <= 1'b1;
      end else begin
        state_reg      <= rcp_pkg::RCP_SETTLE;
        settle_cnt_reg <= 32'(SETTLE_CYCLES);
      end
      meas_abort <= 1'b1;
    end else if (code_t && code_char1 == 8'h31 && !blocked) begin
      state_reg <= rcp_pkg::RCP_HOLD;
    end else begin
      case (state_reg)
        rcp_pkg::RCP_FREE: begin
          if (bus_cmd_req) begin
            meas_abort <= 1'b1;
            meas_start <= 1'b1;
          end else if (meas_done) begin
            result_update <= 1'b1;
            meas_start    <= 1'b1;
          end
        end
        rcp_pkg::RCP_HOLD: begin
          if (serial_poll) begin
            state_reg  <= rcp_pkg::RCP_POLL;
            meas_start <= 1'b1;
          end
        end
        rcp_pkg::RCP_POLL: begin
          if (meas_done) begin
            result_update <= 1'b1;
            state_reg     <= rcp_pkg::RCP_HOLD;
          end
        end
        rcp_pkg::RCP_SETTLE: begin
          // Counting down to one puts the start SETTLE_CYCLES cycles after entry.
          if (settle_cnt_reg <= 32'h1) begin
            state_reg  <= rcp_pkg::RCP_MEAS;
            meas_start <= 1'b1;
          end else begin
            settle_cnt_reg <= settle_cnt_reg - 32'h1;
          end
        end
        rcp_pkg::RCP_MEAS: begin
          if (meas_done) begin
            result_update <= 1'b1;
            result_ready  <= 1'b1;
            state_reg     <= rcp_pkg::RCP_WAIT;
          end
        end
        rcp_pkg::RCP_WAIT: begin
          if (result_read) begin
            result_ready <= 1'b0;
            state_reg    <= rcp_pkg::RCP_HOLD;
          end
        end
        default: state_reg <= rcp_pkg::RCP_FREE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Bus handshake and status outputs
  // ------------------------------------------------------------

  // Bus commands wait for the handshake while a triggered measurement runs.
  assign bus_cmd_ack = bus_cmd_req && !blocked;

  // Outputs are live in free run, during a serial-poll measurement and when a triggered result is shown.
  assign outputs_enable = state_reg == rcp_pkg::RCP_FREE || state_reg == rcp_pkg::RCP_WAIT ||
                          state_reg == rcp_pkg::RCP_POLL;

  // Sweep freezes at its start point under any non free-run trigger.
  assign sweep_halt = sweep_on && state_reg != rcp_pkg::RCP_FREE;
  // The state code goes out unchanged so the status logic can report the trigger mode.
  assign trig_state = state_reg;

endmodule
`default_nettype wire

// file: bench/rcp_props.sv
// Concurrent checks on the ports of the parser and trigger controller.
// Assumes it is bound into rcp_top, with the settling count handed on.
`default_nettype none
module rcp_props #(
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       remote,
  input wire logic       device_clear,
  input wire logic       bus_cmd_req,
  input wire logic       result_read,
  input wire logic       meas_done,
  input wire logic       sweep_on,
  input wire logic       bus_cmd_ack,
  input wire logic       srq,
  input wire logic [7:0] error_code,
  input wire logic       meas_start,
  input wire logic       result_update,
  input wire logic       result_ready,
  input wire logic       outputs_enable,
  input wire logic       sweep_halt,
  input wire logic [2:0] trig_state
);
  timeunit 1ns;
  timeprecision 100ps;
  // Two spare cycles cover the entry and launch registers around the count.
  localparam int SETTLE_MAX = SETTLE_CYCLES + 2;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  err_code_a: assert property (srq |-> error_code == rcp_pkg::ERR_CODE_INVALID)
    else $error("service request without invalid code");
  clear_free_a: assert property (device_clear |=> trig_state == 3'd0)
    else $error("device clear did not force free run");
  remote_free_a: assert property ($rose(remote) |-> ##[1:2] trig_state == 3'd0)
    else $error("entering remote did not force free run");
  hold_quiet_a: assert property (trig_state == 3'd1 |-> !outputs_enable)
    else $error("outputs enabled in hold");
  sweep_stop_a: assert property (sweep_on && trig_state != 3'd0 |-> sweep_halt)
    else $error("sweep not halted outside free run");
  meas_keep_a: assert property (trig_state == 3'd3 && meas_done && !device_clear |=>
    result_ready && trig_state == 3'd4) else $error("triggered result not kept");
  read_hold_a: assert property (trig_state == 3'd4 && result_read |=> trig_state == 3'd1)
    else $error("no return to hold after read");
  no_intr_a: assert property (trig_state == 3'd3 |-> !bus_cmd_ack)
    else $error("bus command acknowledged during triggered measurement");
  free_ack_a: assert property (trig_state == 3'd0 && bus_cmd_req |-> bus_cmd_ack)
    else $error("bus command not serviced in free run");
  free_upd_a: assert property (trig_state == 3'd0 && meas_done |=> result_update)
    else $error("free run result not refreshed");
  settle_go_a: assert property ($changed(trig_state) && trig_state == 3'd2
    |-> ##[1:SETTLE_MAX] meas_start) else $error("settled measurement never started");
endmodule
bind rcp_top rcp_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_props (
  .sys_clk, .reset, .remote, .device_clear, .bus_cmd_req, .result_read, .meas_done, .sweep_on,
  .bus_cmd_ack, .srq, .error_code, .meas_start, .result_update, .result_ready, .outputs_enable,
  .sweep_halt, .trig_state
);
`default_nettype wire

// file: bench/rcp_ctl_model.sv
// Behavioural bus controller that sends program strings one byte per strobe.
// Assumes the listener takes a byte at a rising edge where rx_ready is high.
`default_nettype none
module rcp_ctl_model (
  input  wire logic       sys_clk,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end
  // Bytes go back to back; each is held until taken, so a refusal only stalls.
  task automatic put_str(input string s);
    @(posedge sys_clk);
    for (int i = 0; i < s.len(); i++) begin
      #1;
      rx_valid = 1'b1;
      rx_byte  = s[i];
      do @(posedge sys_clk); while (rx_ready !== 1'b1);
    end
    #1;
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;  // Released lines must not keep showing the last byte.
  endtask
endmodule
`default_nettype wire

// file: bench/rcp_top_tb.sv
// Self-checking bench for rcp_top, with a controller model sending program text.
// Assumes measurement completion and bus events are pulsed by the bench itself.
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, a, e); end end
module rcp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, reset = 1'b1, remote = 1'b1, lockout = 1'b0, device_clear = 1'b0;
  logic go_local = 1'b0, group_trigger = 1'b0, listen_addr = 1'b0, serial_poll = 1'b0;
  logic bus_cmd_req = 1'b0, srq_clear = 1'b0, clear_key = 1'b0, result_read = 1'b0;
  logic meas_done = 1'b0, sweep_on = 1'b0, rx_valid, rx_ready, bus_cmd_ack, code_valid;
  logic [7:0] rx_byte, code_char0, code_char1, error_code;
  logic [3:0] group_off, num_digit, grp_acc;
  logic num_digit_valid, num_point, num_sign_neg, srq, meas_start, meas_abort;
  logic result_update, result_ready, outputs_enable, sweep_halt;
  logic [2:0] trig_state;
  logic [15:0] code_q;
  logic [3:0] dq[$];
  int fails = 0, tests_run = 0, starts = 0, aborts = 0, upd = 0, n0;
  rcp_top #(.SETTLE_CYCLES(4)) i_dut (.sys_clk, .reset, .rx_valid, .rx_byte, .remote, .lockout,
    .device_clear, .go_local, .group_trigger, .listen_addr, .serial_poll, .bus_cmd_req, .srq_clear,
    .clear_key, .result_read, .meas_done, .sweep_on, .rx_ready, .bus_cmd_ack, .code_char0,
    .code_char1, .code_valid, .group_off, .num_digit, .num_digit_valid, .num_point, .num_sign_neg,
    .srq, .error_code, .meas_start, .meas_abort, .result_update, .result_ready, .outputs_enable,
    .sweep_halt, .trig_state);
  rcp_ctl_model i_ctl (.sys_clk, .rx_ready, .rx_valid, .rx_byte);
  initial forever #5 sys_clk = ~sys_clk;
  // Pulses are counted here so that one-cycle outputs are never missed.
  always @(posedge sys_clk) begin
    if (code_valid === 1'b1) code_q = {code_char0, code_char1};
    if (num_digit_valid === 1'b1) dq.push_back(num_digit);
    grp_acc |= group_off;
    starts += (meas_start === 1'b1);
    aborts += (meas_abort === 1'b1);
    upd += (result_update === 1'b1);
  end
  task automatic pulse(ref logic s);
    @(posedge sys_clk);
    #1 s = 1'b1;
    @(posedge sys_clk);
    #1 s = 1'b0;
  endtask
  // Ends just after the edge, so outputs have settled and new drives are off the edge.
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_codes();
    i_ctl.put_str("t1");
    wt(4);
    `CHK(code_q, {"T", "1"})
    `CHK(trig_state, 3'd1)
    `CHK(outputs_enable, 1'b0)
    i_ctl.put_str(" T0");
    wt(4);
    `CHK(trig_state, 3'd0)
  endtask
  task automatic t_invalid();
    logic [7:0] bad [14] = '{"B", "E", "G", "I", "J", "N", "Q", "Y", "Z", "\\", "{", "}", "~", 8'h7F};
    string s;
    foreach (bad[i]) begin
      s = "x";
      s[0] = bad[i];
      i_ctl.put_str(s);
      wt(2);
      `CHK(srq, 1'b1)
      `CHK(error_code, rcp_pkg::ERR_CODE_INVALID)
      pulse(srq_clear);
      wt(1);
      `CHK(srq, 1'b0)
    end
    i_ctl.put_str("T1");
    wt(4);
    `CHK(trig_state, 3'd1)
  endtask
  task automatic t_group_num();
    string g [4] = '{"H0", "L0", "R0", "W0"};
    logic [3:0] e [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h0, 4'h1};
    foreach (g[i]) begin
      grp_acc = 4'h0;
      i_ctl.put_str(g[i]);
      wt(4);
      `CHK(grp_acc, 4'h1 << i)
    end
    dq.delete();
    i_ctl.put_str("-.12345E1 ");
    wt(4);
    `CHK(srq, 1'b0)
    `CHK(num_sign_neg, 1'b1)
    `CHK(dq.size(), 7)
    foreach (e[i]) if (i < dq.size()) `CHK(dq[i], e[i])
  endtask
  task automatic t_trig();
    n0 = starts;
    i_ctl.put_str("T2");
    wt(4);
    `CHK(starts, n0 + 1)
    bus_cmd_req = 1'b1;
    wt(1);
    `CHK(bus_cmd_ack, 1'b0)
    pulse(meas_done);
    wt(1);
    `CHK(result_ready, 1'b1)
    bus_cmd_req = 1'b0;
    pulse(listen_addr);
    wt(8);
    `CHK(starts, n0 + 2)
    pulse(meas_done);
    pulse(clear_key);
    wt(1);
    `CHK(starts, n0 + 2)
    wt(8);
    `CHK(starts, n0 + 3)
    pulse(meas_done);
    pulse(result_read);
    wt(1);
    `CHK(trig_state, 3'd1)
    lockout = 1'b1;
    pulse(clear_key);
    wt(8);
    `CHK(trig_state, 3'd1)
    lockout = 1'b0;
    pulse(group_trigger);
    wt(2);
    `CHK(trig_state, 3'd2)
    wt(8);
    pulse(meas_done);
    pulse(result_read);
  endtask
  task automatic t_free();
    n0 = starts;
    pulse(serial_poll);
    wt(3);
    `CHK(starts, n0 + 1)
    pulse(meas_done);
    wt(2);
    `CHK(trig_state, 3'd1)
    sweep_on = 1'b1;
    wt(1);
    `CHK(sweep_halt, 1'b1)
    i_ctl.put_str("T0");
    wt(4);
    `CHK(sweep_halt, 1'b0)
    n0 = upd;
    pulse(meas_done);
    wt(1);
    `CHK(upd, n0 + 1)
    n0 = aborts;
    bus_cmd_req = 1'b1;
    wt(3);
    `CHK(aborts > n0, 1'b1)
    bus_cmd_req = 1'b0;
    i_ctl.put_str("T1");
    wt(2);
    `CHK(trig_state, 3'h1)
    pulse(go_local);
    wt(1);
    `CHK(trig_state, 3'h0)
    i_ctl.put_str("T1");
    remote = 1'b0;
    wt(2);
    remote = 1'b1;
    wt(3);
    `CHK(trig_state, 3'd0)
    i_ctl.put_str("T1");
    pulse(device_clear);
    wt(1);
    `CHK(trig_state, 3'd0)
  endtask
  task automatic summarize();
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    wt(16);
    reset = 1'b0;
    `CHK(trig_state, 3'd0)
    t_codes();
    t_invalid();
    t_group_num();
    t_trig();
    t_free();
    summarize();
  end
  initial begin
    wt(20000);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
